// >>> rtl/pas_pkg.sv
// constants and types for the serial voice ports block
package pas_pkg;
   localparam int PAS_AW = 8;
   localparam logic [PAS_AW-1:0] PAS_ADDR_CTRL0 = 8'h00;
   localparam logic [PAS_AW-1:0] PAS_ADDR_CTRL1 = 8'h04;
   localparam logic [PAS_AW-1:0] PAS_ADDR_CTRL3 = 8'h08;
   localparam logic [PAS_AW-1:0] PAS_ADDR_STAT = 8'h0c;
   localparam logic [7:0] PAS_CTRL_RESET = 8'h00;
   localparam int PAS_CTRL0_RUN = 0;
   localparam int PAS_CTRL0_RSTPD = 5;
   localparam int PAS_CTRL0_PD = 6;
   localparam int PAS_CTRL1_FULL = 5;
   localparam int PAS_CTRL1_TRANS = 7;
   localparam int PAS_CTRL3_ROUTE = 5;
   localparam logic [3:0] PAS_PCM_LEN = 4'h8;
   localparam logic [3:0] PAS_THRU_LEN = 4'h4;
   localparam logic [3:0] PAS_ADPCM_LEN = 4'h4;
   localparam logic [3:0] PAS_ADPCM_THRU_LEN = 4'h8;
   // indices into the synchronised input vector
   localparam int PAS_I_PBCLK = 0;
   localparam int PAS_I_PSYNC = 1;
   localparam int PAS_I_ABCLK = 2;
   localparam int PAS_I_ASYNC = 3;
   localparam int PAS_I_RXIN = 4;
   localparam int PAS_I_PDR_N = 8;
   localparam int PAS_I_PDK_N = 9;
   localparam int PAS_I_RANGE = 10;
   localparam int PAS_I_STYLE = 11;
   localparam int PAS_I_HID = 12;
   localparam int PAS_I_FULL = 13;
   localparam int PAS_I_TRANS = 14;
   localparam int PAS_I_ROUTE = 15;
   localparam int PAS_NSYNC = 17;
   typedef enum logic [0:0] {
      PAS_INIT = 1'b0,
      PAS_RUN = 1'b1
   } pas_mode_t;
endpackage : pas_pkg

// >>> rtl/pas_serial_port.sv
// one serial word port: framed shift out and shift in
`timescale 1ns/10ps
`default_nettype none
module pas_serial_port
   import pas_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic enable,
   input wire logic bclk_rise,
   input wire logic bclk_fall,
   input wire logic sync_lvl,
   input wire logic sample_on_fall,
   input wire logic [3:0] word_len,
   input wire logic [7:0] tx_word,
   input wire logic rx_bit,
   output logic tx_out,
   output logic tx_oe,
   output logic [7:0] rx_word,
   output logic rx_valid
);
   typedef struct packed {
      logic armed;
      logic sync_prev;
      logic [3:0] tleft;
      logic [3:0] rleft;
      logic [7:0] tshift;
      logic [7:0] rshift;
      logic [7:0] rx_word;
      logic rx_valid;
      logic out;
      logic oe;
   } pas_port_t;
   pas_port_t s, next_s;
   logic start;
   logic [3:0] cnt;
   logic [7:0] sh;

   assign start = bclk_rise && sync_lvl && !s.sync_prev;

   always_comb begin
      next_s = s;
      cnt = 4'h0;
      sh = 8'h00;
      next_s.rx_valid = 1'b0;
      if (bclk_rise) begin
         next_s.sync_prev = sync_lvl;
      end
      if (!enable) begin
         // idle until a fresh frame edge after enabling
         // disarm and float
         next_s.armed = 1'b0;
         next_s.oe = 1'b0;
         next_s.tleft = 4'h0;
         next_s.rleft = 4'h0;
      end else begin
         if (bclk_rise) begin
            if (start) begin
               next_s.armed = 1'b1;
               next_s.out = tx_word[7];
               next_s.tshift = {tx_word[6:0], 1'b0};
               next_s.tleft = word_len - 4'h1;
               next_s.oe = 1'b1;
            end else if (s.armed && s.tleft != 4'h0) begin
               next_s.out = s.tshift[7];
               next_s.tshift = {s.tshift[6:0], 1'b0};
               next_s.tleft = s.tleft - 4'h1;
               next_s.oe = 1'b1;
            end else begin
               next_s.oe = 1'b0;
            end
            if (start) begin
               next_s.rleft = word_len;
            end
         end
         cnt = (start && !sample_on_fall) ? word_len : s.rleft;
         if (((bclk_fall && sample_on_fall) ||
              (bclk_rise && !sample_on_fall)) &&
             (s.armed || start) && cnt != 4'h0) begin
            sh = {s.rshift[6:0], rx_bit};
            next_s.rshift = sh;
            next_s.rleft = cnt - 4'h1;
            if (cnt == 4'h1) begin
               // left align so a short word lands in the top bits
               next_s.rx_word = sh << (4'h8 - word_len);
               next_s.rx_valid = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign tx_out = s.out;
   assign tx_oe = s.oe;
   assign rx_word = s.rx_word;
   assign rx_valid = s.rx_valid;

   sequence s_frame_start;
      enable && bclk_rise && sync_lvl && !s.sync_prev;
   endsequence
   property p_start_drives;
      @(posedge pclk) disable iff (!presetn)
      s_frame_start |=> tx_oe && (tx_out == $past(tx_word[7]));
   endproperty
   a_start_drives: assert property (p_start_drives)
      else $error("word msb not driven at frame start");
   property p_oe_rise;
      @(posedge pclk) disable iff (!presetn)
      $rose(tx_oe) |-> $past(bclk_rise && enable && sync_lvl);
   endproperty
   a_oe_rise: assert property (p_oe_rise)
      else $error("output enabled without a frame edge");
endmodule : pas_serial_port
`default_nettype wire

// >>> rtl/pas_top.sv
// serial voice ports, routing and power-down control with apb registers
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - reset power-down pin clears all control bits
// - reset power-down pin ORed with ctrl0 bit5
// - keep-state power-down pin preserves control bits
// - keep-state pin ORed with ctrl0 bit6
// - master clock asynchronous to serial clocks
// - pcm out 8 bits msb first, rising
// - all outputs float in power-down or initial
// - pcm in sampled falling edge, msb first
// - full bypass carries routed 4-bit words
// - routing select pins ORed with ctrl3 bits
// - transcoder port timed by adpcm or pcm
// - adpcm out 4 bits msb first, rising
// - transcoder bypass makes adpcm words 8 bits
// - adpcm in sampled rising edge, msb first
// - host interface disable skips initial mode
// - bus style select only reported in status, not acted on
// - adpcm words always in first slot
// - full bypass disables transcoder path
// - transcoder bypass control bypasses transcoder
module pas_top
   import pas_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [pas_pkg::PAS_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic powerdown_with_reset_n,
   input wire logic powerdown_keep_state_n,
   input wire logic master_clock_range_select,
   input wire logic host_interface_disable,
   input wire logic host_bus_style_select,
   input wire logic full_bypass_control,
   input wire logic transcoder_bypass_control,
   input wire logic [1:0] pcm_routing_select,
   input wire logic pcm_bit_clock,
   input wire logic pcm_frame_sync,
   input wire logic adpcm_bit_clock,
   input wire logic adpcm_frame_sync,
   input wire logic acoustic_pcm_in,
   input wire logic transcoder_pcm_in,
   input wire logic line_pcm_in,
   input wire logic adpcm_rx_serial_in,
   output logic acoustic_pcm_out,
   output logic acoustic_pcm_out_oe,
   output logic transcoder_pcm_out,
   output logic transcoder_pcm_out_oe,
   output logic line_pcm_out,
   output logic line_pcm_out_oe,
   output logic adpcm_tx_serial_out,
   output logic adpcm_tx_serial_out_oe
);
   typedef struct packed {
      logic [PAS_NSYNC-1:0] s1;
      logic [PAS_NSYNC-1:0] s2;
      logic [1:0] bprev;
      logic [7:0] ctrl0;
      logic [7:0] ctrl1;
      logic [7:0] ctrl3;
      pas_mode_t mode;
      logic [3:0][7:0] held;
      logic [31:0] rdata;
   } pas_state_t;
   pas_state_t s, next_s;

   // port order: 0 acoustic, 1 transcoder pcm, 2 line, 3 adpcm
   logic [3:0] p_rise, p_fall, p_sync, p_en, p_rxbit;
   logic [3:0] p_out, p_oe, p_valid;
   logic [3:0] p_len [4];
   logic [7:0] p_txw [4];
   logic [7:0] p_rxw [4];
   logic [PAS_NSYNC-1:0] raw;
   logic rst_pd, pd, full, trans, pcm_rise, adp_rise, pcm_fall, adp_fall;
   logic [1:0] route;
   logic wr, rd_setup, mapped;

   // source input for each pcm output under a routing code
   function automatic logic [1:0] pas_src(input logic [1:0] r,
                                          input int unsigned o);
      logic [1:0] m;
      m = 2'(o);
      if (r[0]) begin
         unique case (m)
            2'h0: pas_src = 2'h1;
            2'h1: pas_src = 2'h0;
            default: pas_src = 2'h2;
         endcase
      end else begin
         unique case (m)
            2'h0: pas_src = 2'h2;
            2'h2: pas_src = 2'h0;
            default: pas_src = 2'h1;
         endcase
      end
   endfunction : pas_src

   function automatic logic pas_mapped(input logic [PAS_AW-1:0] a);
      pas_mapped = (a == PAS_ADDR_CTRL0) || (a == PAS_ADDR_CTRL1) ||
                   (a == PAS_ADDR_CTRL3) || (a == PAS_ADDR_STAT);
   endfunction : pas_mapped

   // every outside input is resynchronised to pclk
   assign raw = {pcm_routing_select, transcoder_bypass_control,
                 full_bypass_control, host_interface_disable,
                 host_bus_style_select, master_clock_range_select,
                 powerdown_keep_state_n, powerdown_with_reset_n,
                 adpcm_rx_serial_in, line_pcm_in, transcoder_pcm_in,
                 acoustic_pcm_in, adpcm_frame_sync, adpcm_bit_clock,
                 pcm_frame_sync, pcm_bit_clock};

   // reset power-down from pin or bit
   assign rst_pd = !s.s2[PAS_I_PDR_N] || s.ctrl0[PAS_CTRL0_RSTPD];
   // keep-state power-down from pin or bit
   assign pd = rst_pd || !s.s2[PAS_I_PDK_N] || s.ctrl0[PAS_CTRL0_PD];
   // full bypass pin ORed with its bit
   assign full = s.s2[PAS_I_FULL] || s.ctrl1[PAS_CTRL1_FULL];
   // transcoder bypass pin ORed with its bit
   assign trans = s.s2[PAS_I_TRANS] || s.ctrl1[PAS_CTRL1_TRANS];
   // routing pins ORed with ctrl3 bits
   assign route = s.s2[PAS_I_ROUTE +: 2] |
                  s.ctrl3[PAS_CTRL3_ROUTE +: 2];
   assign pcm_rise = s.s2[PAS_I_PBCLK] && !s.bprev[0];
   assign pcm_fall = !s.s2[PAS_I_PBCLK] && s.bprev[0];
   assign adp_rise = s.s2[PAS_I_ABCLK] && !s.bprev[1];
   assign adp_fall = !s.s2[PAS_I_ABCLK] && s.bprev[1];

   assign wr = psel && penable && pwrite;
   assign rd_setup = psel && !penable;
   assign mapped = pas_mapped(paddr);

   always_comb begin
      for (int i = 0; i < 4; i++) begin
         p_rise[i] = pcm_rise;
         p_fall[i] = pcm_fall;
         p_sync[i] = s.s2[PAS_I_PSYNC];
         p_rxbit[i] = s.s2[PAS_I_RXIN + i];
         // float in power-down or initial mode
         p_en[i] = !pd && (s.mode == PAS_RUN);
         // eight bit words, four in full bypass
         p_len[i] = full ? PAS_THRU_LEN : PAS_PCM_LEN;
         p_txw[i] = s.held[pas_src(route, i)];
      end
      // transcoder pcm port on adpcm timing for upper codes
      if (route[1]) begin
         p_rise[1] = adp_rise;
         p_fall[1] = adp_fall;
         p_sync[1] = s.s2[PAS_I_ASYNC];
      end
      // decoder stand-in: received adpcm code feeds transcoder out
      if (!full) begin
         p_txw[1] = s.held[3];
      end
      // adpcm port only ever uses the first slot
      p_rise[3] = adp_rise;
      p_fall[3] = adp_fall;
      p_sync[3] = s.s2[PAS_I_ASYNC];
      // transcoder path off in full bypass
      p_en[3] = !pd && (s.mode == PAS_RUN) && !full;
      // four bit code, eight in bypass
      p_len[3] = trans ? PAS_ADPCM_THRU_LEN : PAS_ADPCM_LEN;
      // encoder stand-in: upper bits of the transcoder pcm input
      p_txw[3] = s.held[1];
   end

   always_comb begin
      next_s = s;
      next_s.s1 = raw;
      // first stage feeds only the second stage
      next_s.s2 = s.s1;
      next_s.bprev = {s.s2[PAS_I_ABCLK], s.s2[PAS_I_PBCLK]};
      for (int i = 0; i < 4; i++) begin
         if (p_valid[i]) begin
            next_s.held[i] = p_rxw[i];
         end
      end
      if (wr) begin
         if (paddr == PAS_ADDR_CTRL0) begin
            next_s.ctrl0 = pwdata[7:0];
         end
         if (paddr == PAS_ADDR_CTRL1) begin
            next_s.ctrl1 = pwdata[7:0];
         end
         if (paddr == PAS_ADDR_CTRL3) begin
            next_s.ctrl3 = pwdata[7:0];
         end
      end
      // skip initial mode when host interface unused
      if (!pd && (s.s2[PAS_I_HID] || s.ctrl0[PAS_CTRL0_RUN])) begin
         next_s.mode = PAS_RUN;
      end
      // reset power-down returns control bits to initial
      if (rst_pd) begin
         next_s.ctrl0 = PAS_CTRL_RESET;
         next_s.ctrl1 = PAS_CTRL_RESET;
         next_s.ctrl3 = PAS_CTRL_RESET;
         next_s.mode = PAS_INIT;
      end
      // read data captured in setup so it stands through access
      if (rd_setup) begin
         next_s.rdata = 32'h0000_0000;
         if (paddr == PAS_ADDR_CTRL0) begin
            next_s.rdata[7:0] = s.ctrl0;
         end
         if (paddr == PAS_ADDR_CTRL1) begin
            next_s.rdata[7:0] = s.ctrl1;
         end
         if (paddr == PAS_ADDR_CTRL3) begin
            next_s.rdata[7:0] = s.ctrl3;
         end
         if (paddr == PAS_ADDR_STAT) begin
            // style and range strap levels reported, not acted on
            next_s.rdata[7:0] = {route, trans, full,
                                 s.s2[PAS_I_STYLE], s.s2[PAS_I_RANGE],
                                 s.mode == PAS_RUN, pd};
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_port
         // pcm inputs sample falling, adpcm rising
         pas_serial_port u_port (
            .pclk(pclk),
            .presetn(presetn),
            .enable(p_en[g]),
            .bclk_rise(p_rise[g]),
            .bclk_fall(p_fall[g]),
            .sync_lvl(p_sync[g]),
            .sample_on_fall(g != 3),
            .word_len(p_len[g]),
            .tx_word(p_txw[g]),
            .rx_bit(p_rxbit[g]),
            .tx_out(p_out[g]),
            .tx_oe(p_oe[g]),
            .rx_word(p_rxw[g]),
            .rx_valid(p_valid[g])
         );
      end
   endgenerate

   // no wait states; unmapped addresses answer with an error
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign prdata = s.rdata;
   assign acoustic_pcm_out = p_out[0];
   assign acoustic_pcm_out_oe = p_oe[0];
   assign transcoder_pcm_out = p_out[1];
   assign transcoder_pcm_out_oe = p_oe[1];
   assign line_pcm_out = p_out[2];
   assign line_pcm_out_oe = p_oe[2];
   assign adpcm_tx_serial_out = p_out[3];
   assign adpcm_tx_serial_out_oe = p_oe[3];

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_rst_clear;
      !s.s2[PAS_I_PDR_N] |=> s.ctrl0 == 8'h00 && s.ctrl1 == 8'h00 &&
                             s.ctrl3 == 8'h00 && s.mode == PAS_INIT;
   endproperty
   a_rst_clear: assert property (p_rst_clear)
      else $error("control bits not cleared by reset power-down");
   property p_rst_bit;
      s.ctrl0[PAS_CTRL0_RSTPD] |=> s.ctrl0 == 8'h00 && !p_oe[0];
   endproperty
   a_rst_bit: assert property (p_rst_bit)
      else $error("ctrl0 reset bit did not act as the pin");
   property p_keep;
      !s.s2[PAS_I_PDK_N] && s.s2[PAS_I_PDR_N] &&
      !s.ctrl0[PAS_CTRL0_RSTPD] && !wr |=>
      $stable(s.ctrl1) && $stable(s.ctrl3);
   endproperty
   a_keep: assert property (p_keep)
      else $error("control bits lost in keep-state power-down");
   property p_pd_float;
      pd || s.mode == PAS_INIT |=> p_oe == 4'h0;
   endproperty
   a_pd_float: assert property (p_pd_float)
      else $error("serial output driven while powered down");
   property p_hid;
      s.s2[PAS_I_HID] && !pd |=> s.mode == PAS_RUN;
   endproperty
   a_hid: assert property (p_hid)
      else $error("initial mode not skipped");
   property p_route_bit;
      wr && paddr == PAS_ADDR_CTRL3 && pwdata[6] && !rst_pd |=>
      route[1] && p_rise[1] == adp_rise;
   endproperty
   a_route_bit: assert property (p_route_bit)
      else $error("routing bit did not take effect");
   property p_full_quiet;
      full |=> !p_oe[3];
   endproperty
   a_full_quiet: assert property (p_full_quiet)
      else $error("adpcm output active in full bypass");
   property p_adp_len;
      trans |-> p_len[3] == PAS_ADPCM_THRU_LEN;
   endproperty
   a_adp_len: assert property (p_adp_len)
      else $error("adpcm word length wrong in bypass");
endmodule : pas_top
`default_nettype wire

// >>> tb/pas_far_end.sv
// far side model: codec and baseband controller on the serial ports
`timescale 1ns/10ps
`default_nettype none
module pas_far_end (
   output logic pcm_bit_clock,
   output logic pcm_frame_sync,
   output logic adpcm_bit_clock,
   output logic adpcm_frame_sync,
   output logic [3:0] din,
   input wire logic [3:0] dout,
   input wire logic [3:0] doe,
   input wire logic [3:0][7:0] wr,
   output logic [3:0][7:0] got,
   output logic [3:0][3:0] cnt
);
   initial begin
      pcm_bit_clock = 1'b0;
      adpcm_bit_clock = 1'b0;
      pcm_frame_sync = 1'b0;
      adpcm_frame_sync = 1'b0;
      // inputs idle high through their pull-ups
      din = 4'hf;
      got = '0;
      cnt = '0;
   end
   // one frame of 12 bit slots, 80 ns each; clocks stand still after it
   task automatic frame;
      int k;
      int i;
      got = '0;
      cnt = '0;
      for (k = 0; k < 12; k++) begin
         pcm_bit_clock = 1'b1;
         for (i = 0; i < 3; i++) begin
            din[i] = (k >= 1 && k <= 8) ? wr[i][8-k] : 1'b1;
         end
         // adpcm clock offset, not tied to pclk
         #6 adpcm_bit_clock = 1'b1;
         #34 pcm_bit_clock = 1'b0;
         // sync changes on bit clock fall
         pcm_frame_sync = (k == 0);
         #6 adpcm_bit_clock = 1'b0;
         adpcm_frame_sync = (k == 0);
         din[3] = (k <= 7) ? wr[3][7-k] : 1'b1;
         #24;
         for (i = 0; i < 4; i++) begin
            if (doe[i]) begin
               got[i] = {got[i][6:0], dout[i]};
               cnt[i] = cnt[i] + 4'h1;
            end
         end
         #10;
      end
      #160;
   endtask : frame
endmodule : pas_far_end
`default_nettype wire

// >>> tb/testbench.sv
// self-checking bench: apb register access and serial frames
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
   n_mismatch++; \
   $display("unexpected %s: expected %0h seen %0h", nm, e, g); \
end end
module testbench;
   import pas_pkg::*;
   logic pclk, presetn, psel, penable, pwrite;
   logic [PAS_AW-1:0] paddr;
   logic [31:0] pwdata, rdv;
   wire logic [31:0] prdata;
   wire logic pready, pslverr;
   logic pdr_n, pdk_n, range_sel, hid, style, full, trans, err;
   logic [1:0] route;
   logic [3:0][7:0] wr;
   wire logic pbclk, psync, abclk, asyn;
   wire logic [3:0] din, dout, doe;
   wire logic [3:0][7:0] got;
   wire logic [3:0][3:0] cnt;
   int n_mismatch, cmp_count, r, i;

   pas_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .powerdown_with_reset_n(pdr_n), .powerdown_keep_state_n(pdk_n),
      .master_clock_range_select(range_sel), .host_interface_disable(hid),
      .host_bus_style_select(style), .full_bypass_control(full),
      .transcoder_bypass_control(trans), .pcm_routing_select(route),
      .pcm_bit_clock(pbclk), .pcm_frame_sync(psync),
      .adpcm_bit_clock(abclk), .adpcm_frame_sync(asyn),
      .acoustic_pcm_in(din[0]), .transcoder_pcm_in(din[1]),
      .line_pcm_in(din[2]), .adpcm_rx_serial_in(din[3]),
      .acoustic_pcm_out(dout[0]), .acoustic_pcm_out_oe(doe[0]),
      .transcoder_pcm_out(dout[1]), .transcoder_pcm_out_oe(doe[1]),
      .line_pcm_out(dout[2]), .line_pcm_out_oe(doe[2]),
      .adpcm_tx_serial_out(dout[3]), .adpcm_tx_serial_out_oe(doe[3]));

   pas_far_end far (.pcm_bit_clock(pbclk), .pcm_frame_sync(psync),
      .adpcm_bit_clock(abclk), .adpcm_frame_sync(asyn), .din(din),
      .dout(dout), .doe(doe), .wr(wr), .got(got), .cnt(cnt));

   always #4 pclk = ~pclk;

   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rdv = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      apb(1'b0, a, 8'h00);
      `CHK("register", {24'h0, e}, rdv)
   endtask : rd_chk

   task automatic settle;
      repeat (6) @(posedge pclk);
   endtask : settle

   // output words lag input words by one frame
   task automatic frames(input int n);
      repeat (n) begin
         @(posedge pclk);
         #3;
         far.frame();
      end
   endtask : frames

   task automatic chk_port(input int p, input logic [3:0] n,
                           input logic [7:0] w, input logic [7:0] m);
      logic [7:0] al;
      al = (n == 4'h4) ? {got[p][3:0], 4'h0} : got[p];
      `CHK("oe slots", n, cnt[p])
      `CHK("port word", w & m, al & m)
   endtask : chk_port

   task automatic chk_idle;
      for (i = 0; i < 4; i++) `CHK("oe slots", 4'h0, cnt[i])
   endtask : chk_idle

   task automatic end_of_test;
      $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : end_of_test

   initial begin
      #300000;
      n_mismatch++;
      end_of_test();
   end

   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {pdr_n, pdk_n, range_sel} = 3'b111;
      {hid, style, full, trans, route} = '0;
      wr = {8'h9b, 8'hc6, 8'h3c, 8'ha5};
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      settle();
      rd_chk(PAS_ADDR_CTRL0, 8'h00);
      rd_chk(PAS_ADDR_CTRL1, 8'h00);
      rd_chk(PAS_ADDR_CTRL3, 8'h00);
      `CHK("slverr", 1'b0, err)
      rd_chk(PAS_ADDR_STAT, 8'h04);
      apb(1'b1, 8'h10, 8'hff);
      `CHK("slverr", 1'b1, err)
      rd_chk(8'h10, 8'h00);
      `CHK("slverr", 1'b1, err)
      frames(2);
      chk_idle();
      apb(1'b1, PAS_ADDR_CTRL0, 8'h01);
      rd_chk(PAS_ADDR_STAT, 8'h06);
      frames(3);
      chk_port(0, 4'h8, wr[2], 8'hff);
      chk_port(2, 4'h8, wr[0], 8'hff);
      chk_port(1, 4'h8, wr[3], 8'hf0);
      chk_port(3, 4'h4, wr[1], 8'hf0);
      @(posedge pclk);
      trans <= 1'b1;
      frames(3);
      rd_chk(PAS_ADDR_STAT, 8'h26);
      chk_port(3, 4'h8, wr[1], 8'hff);
      chk_port(1, 4'h8, wr[3], 8'hff);
      @(posedge pclk);
      trans <= 1'b0;
      apb(1'b1, PAS_ADDR_CTRL1, 8'h20);
      // full bypass: every routing code, pcm ports carry 4-bit words
      for (r = 0; r < 4; r++) begin
         @(posedge pclk);
         route <= r[1:0];
         frames(3);
         rd_chk(PAS_ADDR_STAT, {r[1:0], 6'h16});
         chk_port(0, 4'h4, r[0] ? wr[1] : wr[2], 8'hf0);
         chk_port(1, 4'h4, r[0] ? wr[0] : wr[1], 8'hf0);
         chk_port(2, 4'h4, r[0] ? wr[2] : wr[0], 8'hf0);
         `CHK("oe slots", 4'h0, cnt[3])
      end
      @(posedge pclk);
      route <= 2'b01;
      full <= 1'b1;
      apb(1'b1, PAS_ADDR_CTRL1, 8'h00);
      apb(1'b1, PAS_ADDR_CTRL3, 8'h40);
      frames(3);
      rd_chk(PAS_ADDR_STAT, 8'hd6);
      chk_port(0, 4'h4, wr[1], 8'hf0);
      `CHK("oe slots", 4'h0, cnt[3])
      @(posedge pclk);
      route <= 2'b00;
      full <= 1'b0;
      apb(1'b1, PAS_ADDR_CTRL3, 8'h00);
      apb(1'b1, PAS_ADDR_CTRL1, 8'h80);
      @(posedge pclk);
      pdk_n <= 1'b0;
      settle();
      apb(1'b0, PAS_ADDR_STAT, 8'h00);
      `CHK("powerdown", 1'b1, rdv[0])
      rd_chk(PAS_ADDR_CTRL0, 8'h01);
      rd_chk(PAS_ADDR_CTRL1, 8'h80);
      frames(2);
      chk_idle();
      @(posedge pclk);
      pdk_n <= 1'b1;
      frames(3);
      chk_port(3, 4'h8, wr[1], 8'hff);
      chk_port(0, 4'h8, wr[2], 8'hff);
      apb(1'b1, PAS_ADDR_CTRL0, 8'h41);
      apb(1'b0, PAS_ADDR_STAT, 8'h00);
      `CHK("powerdown", 1'b1, rdv[0])
      frames(2);
      chk_idle();
      apb(1'b1, PAS_ADDR_CTRL0, 8'h01);
      @(posedge pclk);
      pdr_n <= 1'b0;
      settle();
      apb(1'b1, PAS_ADDR_CTRL0, 8'h01);
      rd_chk(PAS_ADDR_CTRL0, 8'h00);
      rd_chk(PAS_ADDR_CTRL1, 8'h00);
      apb(1'b0, PAS_ADDR_STAT, 8'h00);
      `CHK("mode", 2'b01, rdv[1:0])
      apb(1'b0, PAS_ADDR_STAT, 8'h00);
      `CHK("mode", 2'b01, rdv[1:0])
      @(posedge pclk);
      pdr_n <= 1'b1;
      settle();
      frames(2);
      chk_idle();
      apb(1'b1, PAS_ADDR_CTRL1, 8'h80);
      apb(1'b1, PAS_ADDR_CTRL0, 8'h21);
      rd_chk(PAS_ADDR_CTRL0, 8'h00);
      rd_chk(PAS_ADDR_CTRL1, 8'h00);
      @(posedge pclk);
      hid <= 1'b1;
      style <= 1'b1;
      range_sel <= 1'b0;
      settle();
      rd_chk(PAS_ADDR_STAT, 8'h0a);
      frames(3);
      chk_port(1, 4'h8, wr[3], 8'hf0);
      chk_port(3, 4'h4, wr[1], 8'hf0);
      end_of_test();
   end
endmodule : testbench
`default_nettype wire
